// ==== design/clk_divider_chain.v ====
// Prescaler and 21-stage ripple-style divider, built as enabled counters
`timescale 1ns/100ps
`default_nettype none
`include "clk_mode_consts.vh"
module clk_divider_chain (
  input  wire                    i_sys_clk,
  input  wire                    i_reset_n,
  input  wire                    i_clear,
  input  wire                    i_basic_tick,
  input  wire                    i_low_run,
  input  wire                    i_slow_tick,
  input  wire                    i_stage7_from_slow,
  output reg  [`DIVIDER_W-1:0]   o_stages
);
  reg  [`PRESCALE_W-1:0] pre_q;
  wire                   pre_carry;
  wire [`DIVIDER_W:0]    adv;
  wire                   s6_fall;
  wire                   s7_in;
  assign pre_carry = i_basic_tick & (&pre_q);
  assign s6_fall   = adv[`STAGE6_IDX] & o_stages[`STAGE6_IDX];
  // Stage seven takes either the stage six carry or the slow clock tick
  assign s7_in     = i_stage7_from_slow ? i_slow_tick : s6_fall;
  assign adv[0]    = pre_carry & ~i_low_run;
  // Each stage toggles when all lower stages carry, except that stage seven and above count from the stage seven input
  genvar g;
  generate
    for (g = 0; g < `DIVIDER_W; g = g + 1) begin : g_stage
      if (g == `STAGE7_IDX) begin : g_s7
        assign adv[g+1] = s7_in & o_stages[g];
      end else if (g == `STAGE6_IDX) begin : g_s6
        assign adv[g+1] = 1'b0;
      end else begin : g_std
        assign adv[g+1] = adv[g] & o_stages[g];
      end
    end
  endgenerate
  // Prescaler counts basic clock ticks; cleared on reset and stop edges
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pre_q <= {`PRESCALE_W{1'b0}};
    end else if (i_clear) begin
      pre_q <= {`PRESCALE_W{1'b0}};
    end else if (i_basic_tick & ~i_low_run) begin
      pre_q <= pre_q + 2'h1;
    end
  end
  // Divider stages, stage seven from the selected source
  always @(posedge i_sys_clk or negedge i_reset_n) begin : p_div
    integer k;
    if (!i_reset_n) begin
      o_stages <= {`DIVIDER_W{1'b0}};
    end else if (i_clear) begin
      o_stages <= {`DIVIDER_W{1'b0}};
    end else begin
      for (k = 0; k < `DIVIDER_W; k = k + 1) begin
        if (k == `STAGE7_IDX) begin
          if (s7_in) o_stages[k] <= ~o_stages[k];
        end else if (k < `STAGE7_IDX) begin
          if (i_low_run) o_stages[k] <= 1'b0;
          else if (adv[k]) o_stages[k] <= ~o_stages[k];
        end else if (adv[k]) begin
          o_stages[k] <= ~o_stages[k];
        end
      end
    end
  end
endmodule // clk_divider_chain
`default_nettype wire

// ==== design/clk_mode_consts.vh ====
// Constants for the system clock and operating mode controller
// Functional notes
// - Clocks come from a 2-stage prescaler, 21-stage divider and cycle counter.
// - Prescaler and divider clear on reset and on stop entry or exit.
// - Stage seven input depends on mode, main clock select, stage7 select.
// - In slow run or slow doze, stage7 source select is ignored.
// - Warm-up after stop from fast run feeds stage seven from stage six.
// - A machine cycle is four main clock states; instructions take 1 to 10.
// - Single clock uses fast oscillator only; slow crystal pins are ports.
// - After reset the mode is single fast run on the fast clock.
// - Idle bit halts CPU and watchdog; any interrupt ends doze.
// - Wake with global enable set services interrupt, else continues next.
// - Gate bit stops CPU and non-tick peripherals until tick source falls.
// - Fast nap exits to single fast run; tick enable sets tick latch.
// - Dual clock runs both oscillators; slow modes give four slow periods.
// - Main select one gives dual slow run, zero dual fast; fast off gives slow only.
// - In slow only run and slow dozes, stages one to six stop.
// - Dual fast doze returns to dual fast run; slow only doze stops fast osc.
// - Dual slow doze equals slow only doze but fast oscillator keeps running.
// - Slow nap behaves as fast nap but returns to slow only run.
// - Illegal oscillator enable combinations reset the device.
// - Leaving any doze clears the idle bit.
// - Leaving either nap clears the peripheral clock gate bit.
`ifndef CLK_MODE_CONSTS_VH
`define CLK_MODE_CONSTS_VH
`define PRESCALE_W       2
`define DIVIDER_W        21
`define STATES_PER_CYCLE 4
`define STATE_CNT_W      2
`define STAGE7_IDX       6
`define STAGE6_IDX       5
`define MODE_W           4
`define M_SINGLE_FAST_RUN  4'h0
`define M_SINGLE_FAST_DOZE 4'h1
`define M_FAST_NAP         4'h2
`define M_DUAL_FAST_RUN    4'h3
`define M_DUAL_FAST_DOZE   4'h4
`define M_DUAL_SLOW_RUN    4'h5
`define M_DUAL_SLOW_DOZE   4'h6
`define M_SLOW_ONLY_RUN    4'h7
`define M_SLOW_ONLY_DOZE   4'h8
`define M_SLOW_NAP         4'h9
`define M_STOP             4'hA
`define M_WARMUP           4'hB
`endif

// ==== design/machine_cycle_gen.v ====
// Machine cycle state counter: four main clock states per cycle
`timescale 1ns/100ps
`default_nettype none
`include "clk_mode_consts.vh"
module machine_cycle_gen (
  input  wire                     i_sys_clk,
  input  wire                     i_reset_n,
  input  wire                     i_main_tick,
  input  wire                     i_cpu_run,
  output reg  [`STATE_CNT_W-1:0]  o_state,
  output reg                      o_cycle_end
);
  // Advance one state per main clock tick while the CPU runs
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_state     <= {`STATE_CNT_W{1'b0}};
      o_cycle_end <= 1'b0;
    end else begin
      o_cycle_end <= 1'b0;
      if (i_main_tick & i_cpu_run) begin
        o_state     <= o_state + 2'h1;
        o_cycle_end <= (o_state == `STATES_PER_CYCLE - 1);
      end
    end
  end
endmodule // machine_cycle_gen
`default_nettype wire

// ==== design/system_clock_mode_controller.v ====
// Operating mode state machine with timing generator and clock gating
`timescale 1ns/100ps
`default_nettype none
`include "clk_mode_consts.vh"
module system_clock_mode_controller (
  input  wire                    i_sys_clk,
  input  wire                    i_reset_n,
  input  wire                    i_fast_clock,
  input  wire                    i_slow_clock,
  input  wire                    i_fast_osc_enable,
  input  wire                    i_slow_osc_enable,
  input  wire                    i_main_clock_select,
  input  wire                    i_stage7_source_select,
  input  wire                    i_idle_set,
  input  wire                    i_peripheral_clock_gate_set,
  input  wire                    i_irq_request,
  input  wire                    i_global_irq_enable,
  input  wire                    i_tick_irq_enable,
  input  wire                    i_tick_timer_enable,
  input  wire [`DIVIDER_W-1:0]   i_tick_source_select,
  input  wire                    i_tick_irq_ack,
  input  wire                    i_stop_enter,
  input  wire                    i_stop_release,
  input  wire                    i_warmup_done,
  output reg  [`MODE_W-1:0]      o_mode,
  output reg                     o_idle_bit,
  output reg                     o_peripheral_clock_gate,
  output reg                     o_main_clock_is_slow,
  output wire                    o_fast_osc_on,
  output wire                    o_slow_osc_on,
  output wire                    o_slow_pins_are_ports,
  output wire                    o_cpu_run,
  output wire                    o_watchdog_run,
  output wire                    o_periph_clock_en,
  output wire                    o_tick_clock_en,
  output reg                     o_tick_interrupt_latch,
  output reg                     o_take_interrupt,
  output reg                     o_resume_next,
  output reg                     o_osc_fault_reset,
  output wire [`DIVIDER_W-1:0]   o_divider,
  output wire [`STATE_CNT_W-1:0] o_machine_state,
  output wire                    o_machine_cycle_end
);
  reg  [`MODE_W-1:0] mode_d;
  reg                stop_from_fast_q;
  reg                fast_q;
  reg                slow_q;
  reg                tick_src_q;
  reg                idle_d;
  reg                gate_d;
  reg                latch_d;
  reg                take_d;
  reg                next_d;
  wire               fast_tick;
  wire               slow_tick;
  wire               main_tick;
  wire               tick_src;
  wire               tick_fall;
  wire               slow_main;
  wire               low_run;
  wire               stage7_slow;
  wire               div_clear;
  wire               osc_fault;
  wire               single_mode;
  wire               any_doze;
  wire               any_nap;
  wire               stopped;

  // Mode class decode used in several places
  function is_slow_main;
    input [`MODE_W-1:0] m;
    begin
      is_slow_main = (m == `M_DUAL_SLOW_RUN) | (m == `M_DUAL_SLOW_DOZE) |
                     (m == `M_SLOW_ONLY_RUN) | (m == `M_SLOW_ONLY_DOZE) |
                     (m == `M_SLOW_NAP);
    end
  endfunction

  function is_single;
    input [`MODE_W-1:0] m;
    begin
      is_single = (m == `M_SINGLE_FAST_RUN) | (m == `M_SINGLE_FAST_DOZE) |
                  (m == `M_FAST_NAP);
    end
  endfunction

  // Rising edges of the oscillator inputs become one-cycle ticks
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fast_q     <= 1'b0;
      slow_q     <= 1'b0;
      tick_src_q <= 1'b0;
    end else begin
      fast_q     <= i_fast_clock;
      slow_q     <= i_slow_clock;
      tick_src_q <= tick_src;
    end
  end

  assign stopped     = (o_mode == `M_STOP);
  assign fast_tick   = i_fast_clock & ~fast_q & o_fast_osc_on;
  assign slow_tick   = i_slow_clock & ~slow_q & o_slow_osc_on;
  assign slow_main   = is_slow_main(o_mode);
  assign single_mode = is_single(o_mode);
  // Main clock follows the mode: fast in fast modes, slow in slow modes
  assign main_tick   = slow_main ? slow_tick : fast_tick;
  assign low_run     = (o_mode == `M_SLOW_ONLY_RUN) | (o_mode == `M_SLOW_ONLY_DOZE) |
                       (o_mode == `M_DUAL_SLOW_DOZE) | (o_mode == `M_SLOW_NAP);
  // Select bit ignored in slow modes and during warm-up after fast stop
  assign stage7_slow = i_stage7_source_select & ~slow_main &
                       ~(o_mode == `M_WARMUP & stop_from_fast_q) &
                       ~single_mode & o_slow_osc_on;
  assign div_clear   = ((mode_d == `M_STOP) & ~stopped) |
                       (stopped & i_stop_release);

  // Oscillator control per mode
  assign o_fast_osc_on = ~stopped & (o_mode != `M_SLOW_ONLY_RUN) &
                         (o_mode != `M_SLOW_ONLY_DOZE) & (o_mode != `M_SLOW_NAP) &
                         ~(o_mode == `M_WARMUP & ~stop_from_fast_q);
  assign o_slow_osc_on = ~stopped & ~single_mode &
                         ~(o_mode == `M_WARMUP & stop_from_fast_q & ~i_slow_osc_enable);
  assign o_slow_pins_are_ports = single_mode;

  assign any_doze = (o_mode == `M_SINGLE_FAST_DOZE) | (o_mode == `M_DUAL_FAST_DOZE) |
                    (o_mode == `M_DUAL_SLOW_DOZE) | (o_mode == `M_SLOW_ONLY_DOZE);
  assign any_nap  = (o_mode == `M_FAST_NAP) | (o_mode == `M_SLOW_NAP);
  // CPU and watchdog halt in doze, nap, stop and warm-up
  assign o_cpu_run         = ~any_doze & ~any_nap & ~stopped & (o_mode != `M_WARMUP);
  assign o_watchdog_run    = o_cpu_run;
  assign o_periph_clock_en = ~any_nap & ~stopped & (o_mode != `M_WARMUP);
  assign o_tick_clock_en   = ~stopped;

  // Nap ends on the falling edge of the selected divider tap
  assign tick_src  = |(o_divider & i_tick_source_select);
  assign tick_fall = tick_src_q & ~tick_src;

  // Clearing the enable of the clock in use, or both, resets the device
  assign osc_fault = (~i_fast_osc_enable & ~i_slow_osc_enable) |
                     (~i_fast_osc_enable & ~i_main_clock_select) |
                     (~i_slow_osc_enable & i_main_clock_select);

  // Next mode and self-clearing control bits
  always @* begin
    mode_d  = o_mode;
    idle_d  = o_idle_bit | i_idle_set;
    gate_d  = o_peripheral_clock_gate | i_peripheral_clock_gate_set;
    latch_d = o_tick_interrupt_latch & ~i_tick_irq_ack;
    take_d  = 1'b0;
    next_d  = 1'b0;
    case (o_mode)
      `M_SINGLE_FAST_RUN, `M_DUAL_FAST_RUN, `M_DUAL_SLOW_RUN, `M_SLOW_ONLY_RUN: begin
        if (i_stop_enter) begin
          mode_d = `M_STOP;
        end else if (i_idle_set) begin
          case (o_mode)
            `M_SINGLE_FAST_RUN: mode_d = `M_SINGLE_FAST_DOZE;
            `M_DUAL_FAST_RUN:   mode_d = `M_DUAL_FAST_DOZE;
            `M_DUAL_SLOW_RUN:   mode_d = `M_DUAL_SLOW_DOZE;
            default:            mode_d = `M_SLOW_ONLY_DOZE;
          endcase
        end else if (i_peripheral_clock_gate_set) begin
          mode_d = is_slow_main(o_mode) ? `M_SLOW_NAP : `M_FAST_NAP;
        end else if (o_mode == `M_SINGLE_FAST_RUN) begin
          if (i_slow_osc_enable) mode_d = `M_DUAL_FAST_RUN;
        end else if (o_mode == `M_DUAL_FAST_RUN) begin
          if (i_main_clock_select) mode_d = `M_DUAL_SLOW_RUN;
          else if (~i_slow_osc_enable) mode_d = `M_SINGLE_FAST_RUN;
        end else if (o_mode == `M_DUAL_SLOW_RUN) begin
          if (~i_main_clock_select) mode_d = `M_DUAL_FAST_RUN;
          else if (~i_fast_osc_enable) mode_d = `M_SLOW_ONLY_RUN;
        end else begin
          if (i_fast_osc_enable) mode_d = `M_DUAL_SLOW_RUN;
        end
      end
      `M_SINGLE_FAST_DOZE, `M_DUAL_FAST_DOZE, `M_DUAL_SLOW_DOZE, `M_SLOW_ONLY_DOZE: begin
        if (i_irq_request) begin
          idle_d = 1'b0;
          take_d = i_global_irq_enable;
          next_d = ~i_global_irq_enable;
          case (o_mode)
            `M_SINGLE_FAST_DOZE: mode_d = `M_SINGLE_FAST_RUN;
            `M_DUAL_FAST_DOZE:   mode_d = `M_DUAL_FAST_RUN;
            `M_DUAL_SLOW_DOZE:   mode_d = `M_DUAL_SLOW_RUN;
            default:             mode_d = `M_SLOW_ONLY_RUN;
          endcase
        end
      end
      `M_FAST_NAP, `M_SLOW_NAP: begin
        if (tick_fall) begin
          gate_d = 1'b0;
          mode_d = (o_mode == `M_FAST_NAP) ? `M_SINGLE_FAST_RUN
                                           : `M_SLOW_ONLY_RUN;
          if (i_tick_timer_enable) latch_d = 1'b1;
          take_d = i_tick_timer_enable & i_global_irq_enable & i_tick_irq_enable;
        end
      end
      `M_STOP: begin
        if (i_stop_release) mode_d = `M_WARMUP;
      end
      `M_WARMUP: begin
        if (i_warmup_done) begin
          mode_d = stop_from_fast_q ? `M_SINGLE_FAST_RUN : `M_SLOW_ONLY_RUN;
        end
      end
      default: begin
        mode_d = `M_SINGLE_FAST_RUN;
      end
    endcase
  end

  // Mode register and control bits; reset lands in single fast run
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mode                  <= `M_SINGLE_FAST_RUN;
      o_idle_bit              <= 1'b0;
      o_peripheral_clock_gate <= 1'b0;
      o_tick_interrupt_latch  <= 1'b0;
      o_take_interrupt        <= 1'b0;
      o_resume_next           <= 1'b0;
      o_osc_fault_reset       <= 1'b0;
      o_main_clock_is_slow    <= 1'b0;
      stop_from_fast_q        <= 1'b1;
    end else if (osc_fault & ~stopped & (o_mode != `M_WARMUP) & ~o_osc_fault_reset) begin
      o_mode                  <= `M_SINGLE_FAST_RUN;
      o_idle_bit              <= 1'b0;
      o_peripheral_clock_gate <= 1'b0;
      o_tick_interrupt_latch  <= 1'b0;
      o_take_interrupt        <= 1'b0;
      o_resume_next           <= 1'b0;
      o_osc_fault_reset       <= 1'b1;
      o_main_clock_is_slow    <= 1'b0;
      stop_from_fast_q        <= 1'b1;
    end else begin
      o_mode                  <= mode_d;
      o_idle_bit              <= idle_d;
      o_peripheral_clock_gate <= gate_d;
      o_tick_interrupt_latch  <= latch_d;
      o_take_interrupt        <= take_d;
      o_resume_next           <= next_d;
      o_osc_fault_reset       <= 1'b0;
      o_main_clock_is_slow    <= is_slow_main(mode_d);
      if (mode_d == `M_STOP && o_mode != `M_STOP) begin
        stop_from_fast_q <= ~is_slow_main(o_mode);
      end
    end
  end

  // Timing generator divider chain
  clk_divider_chain u_div (
    .i_sys_clk          (i_sys_clk),
    .i_reset_n          (i_reset_n),
    .i_clear            (div_clear),
    .i_basic_tick       (fast_tick),
    .i_low_run          (low_run),
    .i_slow_tick        (slow_tick),
    .i_stage7_from_slow (stage7_slow | low_run),
    .o_stages           (o_divider)
  );

  // Machine cycle counter on the main clock
  machine_cycle_gen u_mc (
    .i_sys_clk   (i_sys_clk),
    .i_reset_n   (i_reset_n),
    .i_main_tick (main_tick),
    .i_cpu_run   (o_cpu_run),
    .o_state     (o_machine_state),
    .o_cycle_end (o_machine_cycle_end)
  );
endmodule // system_clock_mode_controller
`default_nettype wire

// ==== tb/clk_mode_checker_assertions.sv ====
// Port-level checks for the clock mode controller
`timescale 1ns/100ps
`default_nettype none
`include "clk_mode_consts.vh"
module clk_mode_checker (
  input wire logic                  i_sys_clk,
  input wire logic                  i_reset_n,
  input wire logic                  i_fast_osc_enable,
  input wire logic                  i_slow_osc_enable,
  input wire logic                  i_main_clock_select,
  input wire logic                  i_idle_set,
  input wire logic                  i_peripheral_clock_gate_set,
  input wire logic                  i_irq_request,
  input wire logic                  i_global_irq_enable,
  input wire logic                  i_stop_enter,
  input wire logic [`MODE_W-1:0]    o_mode,
  input wire logic                  o_idle_bit,
  input wire logic                  o_fast_osc_on,
  input wire logic                  o_slow_osc_on,
  input wire logic                  o_slow_pins_are_ports,
  input wire logic                  o_cpu_run,
  input wire logic                  o_watchdog_run,
  input wire logic                  o_periph_clock_en,
  input wire logic                  o_tick_clock_en,
  input wire logic                  o_take_interrupt,
  input wire logic                  o_resume_next,
  input wire logic                  o_osc_fault_reset,
  input wire logic [`DIVIDER_W-1:0] o_divider,
  input wire logic                  o_machine_cycle_end
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // Mode relations checked every cycle
  a_reset_fast_run: assert property ($rose(i_reset_n) |->
    o_mode == `M_SINGLE_FAST_RUN && o_cpu_run) else $error("reset mode");
  a_doze_entry: assert property (o_mode == `M_SINGLE_FAST_RUN && i_idle_set &&
    !i_irq_request && !i_stop_enter && i_fast_osc_enable && !i_slow_osc_enable
    |=> o_mode == `M_SINGLE_FAST_DOZE && o_idle_bit && !o_cpu_run) else $error("doze entry");
  a_doze_wake_path: assert property (o_mode == `M_SINGLE_FAST_DOZE && i_irq_request &&
    !i_stop_enter && i_fast_osc_enable && !i_slow_osc_enable
    |=> o_mode == `M_SINGLE_FAST_RUN && !o_idle_bit &&
    o_take_interrupt == $past(i_global_irq_enable) &&
    o_resume_next != $past(i_global_irq_enable)) else $error("doze wake path");
  a_nap_gating: assert property (o_mode == `M_FAST_NAP || o_mode == `M_SLOW_NAP |->
    !o_cpu_run && !o_periph_clock_en && o_tick_clock_en) else $error("nap gating");
  a_doze_gating: assert property (o_mode inside {`M_SINGLE_FAST_DOZE, `M_DUAL_FAST_DOZE,
    `M_DUAL_SLOW_DOZE, `M_SLOW_ONLY_DOZE} |-> !o_cpu_run && !o_watchdog_run && o_periph_clock_en)
    else $error("doze gating");
  a_single_osc_use: assert property (o_mode inside {`M_SINGLE_FAST_RUN, `M_SINGLE_FAST_DOZE,
    `M_FAST_NAP} |-> o_fast_osc_on && !o_slow_osc_on && o_slow_pins_are_ports)
    else $error("single clock oscillators");
  a_dual_osc_use: assert property (o_mode inside {`M_DUAL_FAST_RUN, `M_DUAL_FAST_DOZE,
    `M_DUAL_SLOW_RUN, `M_DUAL_SLOW_DOZE} |-> o_fast_osc_on && o_slow_osc_on &&
    !o_slow_pins_are_ports) else $error("dual clock oscillators");
  a_slow_only_osc: assert property (o_mode inside {`M_SLOW_ONLY_RUN, `M_SLOW_ONLY_DOZE,
    `M_SLOW_NAP} |-> !o_fast_osc_on && o_slow_osc_on) else $error("slow only oscillators");
  a_select_slow_run: assert property (o_mode == `M_DUAL_FAST_RUN && i_main_clock_select &&
    i_fast_osc_enable && i_slow_osc_enable && !i_idle_set && !i_peripheral_clock_gate_set &&
    !i_stop_enter |=> o_mode == `M_DUAL_SLOW_RUN) else $error("main clock select");
  a_low_stages_hold: assert property (o_mode == `M_SLOW_ONLY_RUN &&
    $past(o_mode) == `M_SLOW_ONLY_RUN |-> o_divider[5:0] == 6'h00) else $error("low stages on");
  a_stop_divider_clear: assert property (o_mode == `M_STOP |-> o_divider == '0)
    else $error("divider not clear in stop");
  a_fault_pulse: assert property (o_mode == `M_SINGLE_FAST_RUN && !i_fast_osc_enable &&
    !i_stop_enter && !o_osc_fault_reset |=> o_osc_fault_reset) else $error("no fault reset");
  a_cycle_spacing: assert property (o_machine_cycle_end |=> !o_machine_cycle_end [*3])
    else $error("short cycle");
endmodule // clk_mode_checker

bind system_clock_mode_controller clk_mode_checker u_checker (.*);
`default_nettype wire

// ==== tb/osc_model.sv ====
// Fast and slow oscillator pair on the far side of the controller
`timescale 1ns/100ps
`default_nettype none
module osc_model #(
  parameter int FAST_HALF = 2,
  parameter int SLOW_HALF = 8
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  input  wire logic i_fast_on,
  input  wire logic i_slow_on,
  output var  logic o_fast_clock,
  output var  logic o_slow_clock
);
  int fast_cnt_q;
  int slow_cnt_q;
  // An oscillator swings only while powered; a stopped one rests low
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fast_cnt_q <= 0;
      slow_cnt_q <= 0;
      o_fast_clock <= 1'b0;
      o_slow_clock <= 1'b0;
    end else begin
      fast_cnt_q <= (i_fast_on && fast_cnt_q < FAST_HALF - 1) ? fast_cnt_q + 1 : 0;
      slow_cnt_q <= (i_slow_on && slow_cnt_q < SLOW_HALF - 1) ? slow_cnt_q + 1 : 0;
      o_fast_clock <= !i_fast_on ? 1'b0 : (fast_cnt_q == FAST_HALF - 1) ^ o_fast_clock;
      o_slow_clock <= !i_slow_on ? 1'b0 : (slow_cnt_q == SLOW_HALF - 1) ^ o_slow_clock;
    end
  end
endmodule // osc_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Directed bench for the system clock and operating mode controller
`timescale 1ns/100ps
`default_nettype none
`include "clk_mode_consts.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module testbench;
  logic i_sys_clk = 1'b0, i_reset_n = 1'b0, i_fast_clock, i_slow_clock, took, resumed, fo;
  logic i_fast_osc_enable = 1'b1, i_slow_osc_enable = 1'b0, i_main_clock_select = 1'b0;
  logic i_stage7_source_select = 1'b0, i_idle_set = 1'b0, i_peripheral_clock_gate_set = 1'b0;
  logic i_irq_request = 1'b0, i_global_irq_enable = 1'b1, i_tick_irq_enable = 1'b1;
  logic i_tick_timer_enable = 1'b1, i_tick_irq_ack = 1'b0, i_stop_enter = 1'b0;
  logic i_stop_release = 1'b0, i_warmup_done = 1'b0;
  logic [`DIVIDER_W-1:0] i_tick_source_select = 21'h000004, o_divider;
  logic [`MODE_W-1:0] o_mode;
  logic [`STATE_CNT_W-1:0] o_machine_state;
  logic o_idle_bit, o_peripheral_clock_gate, o_main_clock_is_slow, o_fast_osc_on, o_slow_osc_on;
  logic o_slow_pins_are_ports, o_cpu_run, o_watchdog_run, o_periph_clock_en, o_tick_clock_en;
  logic o_tick_interrupt_latch, o_take_interrupt, o_resume_next, o_osc_fault_reset;
  logic o_machine_cycle_end;
  int n_mismatch = 0, check_count = 0, gap;
  // 100 MHz system clock
  always #5 i_sys_clk = ~i_sys_clk;
  system_clock_mode_controller dut (.*);
  osc_model u_osc (.i_sys_clk, .i_reset_n, .i_fast_on(o_fast_osc_on), .i_slow_on(o_slow_osc_on),
    .o_fast_clock(i_fast_clock), .o_slow_clock(i_slow_clock));
  // Counts, verdict and end of run
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic step;
    @(posedge i_sys_clk);
    #1;
  endtask
  // One-cycle write: 0 idle, 1 gate, 2 stop, 3 release, else ack; one bit each
  task automatic pulse(input int which);
    @(posedge i_sys_clk);
    case (which)
      0: i_idle_set <= 1'b1;
      1: i_peripheral_clock_gate_set <= 1'b1;
      2: i_stop_enter <= 1'b1;
      3: i_stop_release <= 1'b1;
      default: i_tick_irq_ack <= 1'b1;
    endcase
    @(posedge i_sys_clk);
    {i_idle_set, i_peripheral_clock_gate_set, i_stop_enter, i_stop_release, i_tick_irq_ack} <= 5'h00;
  endtask
  // Bounded wait for a mode; catches exit pulses
  task automatic wait_mode(input logic [3:0] m, input int bound);
    int n = 0;
    do begin
      step();
      n++;
    end while (o_mode !== m && n < bound);
    took = o_take_interrupt;
    resumed = o_resume_next;
    if (o_mode !== m) begin
      n_mismatch++;
      $display("wrong value at %0t: mode wait ran out", $time);
      conclude();
    end
  endtask
  // Gap between cycle ends
  task automatic cycle_gap(output int g);
    int n = 0;
    g = 0;
    while (o_machine_cycle_end !== 1'b1 && n < 500) begin
      step();
      n++;
    end
    do begin
      step();
      g++;
    end while (o_machine_cycle_end !== 1'b1 && g < 500);
  endtask
  // Doze by the idle bit, wake by interrupt
  task automatic doze(input logic [3:0] dz, input logic [3:0] back);
    pulse(0);
    wait_mode(dz, 5);
    fo = o_fast_osc_on;
    `CHK({o_idle_bit, o_cpu_run, o_watchdog_run, o_periph_clock_en}, 4'h9)
    @(posedge i_sys_clk);
    i_irq_request <= 1'b1;
    wait_mode(back, 20);
    `CHK(o_idle_bit, 1'b0)
    @(posedge i_sys_clk);
    i_irq_request <= 1'b0;
  endtask
  // Nap by the gate bit, ended by the tick tap
  task automatic nap(input logic [3:0] np, input logic [3:0] back);
    pulse(1);
    wait_mode(np, 5);
    `CHK({o_cpu_run, o_periph_clock_en, o_tick_clock_en, o_peripheral_clock_gate}, 4'h3)
    wait_mode(back, 3000);
    `CHK(o_peripheral_clock_gate, 1'b0)
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    step();
    `CHK(o_mode, `M_SINGLE_FAST_RUN)
    `CHK({o_slow_pins_are_ports, o_fast_osc_on, o_slow_osc_on, o_divider}, 24'hC00000)
    repeat (2) cycle_gap(gap);
    `CHK(gap, 16)
    for (int k = 0; k < 2; k++) begin
      @(posedge i_sys_clk);
      i_global_irq_enable <= (k == 0);
      doze(`M_SINGLE_FAST_DOZE, `M_SINGLE_FAST_RUN);
      `CHK({took, resumed}, {k == 0, k == 1})
    end
    @(posedge i_sys_clk);
    i_fast_osc_enable <= 1'b0;
    step();
    `CHK({o_osc_fault_reset, o_mode}, {1'b1, `M_SINGLE_FAST_RUN})
    @(posedge i_sys_clk);
    i_fast_osc_enable <= 1'b1;
    for (int t = 1; t >= 0; t--) begin
      @(posedge i_sys_clk);
      i_tick_timer_enable <= t[0];
      nap(`M_FAST_NAP, `M_SINGLE_FAST_RUN);
      `CHK(o_tick_interrupt_latch, t[0])
      pulse(4);
      step();
      `CHK(o_tick_interrupt_latch, 1'b0)
    end
    @(posedge i_sys_clk);
    i_slow_osc_enable <= 1'b1;
    i_tick_timer_enable <= 1'b1;
    wait_mode(`M_DUAL_FAST_RUN, 10);
    `CHK({o_slow_pins_are_ports, o_slow_osc_on, o_fast_osc_on}, 3'h3)
    repeat (40) step();
    @(posedge i_sys_clk);
    i_stage7_source_select <= 1'b1;
    i_main_clock_select <= 1'b1;
    wait_mode(`M_DUAL_SLOW_RUN, 10);
    repeat (2) cycle_gap(gap);
    `CHK({o_main_clock_is_slow, gap == 64}, 2'h3)
    doze(`M_DUAL_SLOW_DOZE, `M_DUAL_SLOW_RUN);
    `CHK(fo, 1'b1)
    @(posedge i_sys_clk);
    i_fast_osc_enable <= 1'b0;
    wait_mode(`M_SLOW_ONLY_RUN, 10);
    repeat (50) step();
    `CHK({o_fast_osc_on, o_divider[5:0]}, 7'h00)
    doze(`M_SLOW_ONLY_DOZE, `M_SLOW_ONLY_RUN);
    `CHK(fo, 1'b0)
    @(posedge i_sys_clk);
    i_tick_source_select <= 21'h000040;
    nap(`M_SLOW_NAP, `M_SLOW_ONLY_RUN);
    `CHK(o_tick_interrupt_latch, 1'b1)
    pulse(4);
    @(posedge i_sys_clk);
    i_fast_osc_enable <= 1'b1;
    wait_mode(`M_DUAL_SLOW_RUN, 10);
    @(posedge i_sys_clk);
    i_main_clock_select <= 1'b0;
    i_stage7_source_select <= 1'b0;
    wait_mode(`M_DUAL_FAST_RUN, 10);
    doze(`M_DUAL_FAST_DOZE, `M_DUAL_FAST_RUN);
    @(posedge i_sys_clk);
    i_slow_osc_enable <= 1'b0;
    wait_mode(`M_SINGLE_FAST_RUN, 10);
    pulse(2);
    step();
    `CHK({o_mode, o_divider}, {`M_STOP, 21'h000000})
    pulse(3);
    wait_mode(`M_WARMUP, 5);
    @(posedge i_sys_clk);
    i_warmup_done <= 1'b1;
    wait_mode(`M_SINGLE_FAST_RUN, 10);
    @(posedge i_sys_clk);
    i_warmup_done <= 1'b0;
    conclude();
  end
endmodule // testbench
`default_nettype wire
